// ### lsmu_pkg.sv
// constants and carrier types of the upper line status monitor
// assumes one 200 MHz clock and a byte-wide register port
package lsmu_pkg;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0] LIVE_LINE_STATUS_0_ADDR = 8'h17;
  localparam logic [7:0] REMOTE_LOOP_STAT_ADDR   = 8'h18;
  localparam logic [7:0] IRQ_STATUS_ADDR         = 8'h19;
  localparam logic [7:0] IRQ_MASK_ADDR           = 8'h14;
  localparam logic [7:0] EDGE_SELECT_ADDR        = 8'h16;
  localparam logic [7:0] LINE_CTRL_ADDR          = 8'h1b;

  // field layout: four indicators sit in bits 6..3
  localparam int FLD_LO      = 3;
  localparam int FLD_HI      = 6;
  localparam int REMOTE_BIT  = 5;
  localparam int CTRL_AUTO   = 0;
  localparam int CTRL_E1     = 1;

  // reset values
  localparam logic [3:0] MASK_RST = 4'hf;
  localparam logic [3:0] ES_RST   = 4'h0;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int  CLK_MHZ      = 200;
  localparam int  QUAL_OFF_MS  = 40;
  localparam real QUAL_ON_S    = 5.1;
  localparam int  QUAL_OFF_CYC = QUAL_OFF_MS * CLK_MHZ * 1000;
  localparam int  QUAL_ON_CYC  = int'(QUAL_ON_S * CLK_MHZ * 1.0e6);
  localparam int  QUAL_W       = 31;
  localparam logic [6:0] TXC_LOSS_CYC = 7'h46; // 70 cycles
  localparam int  TXC_W        = 7;

  // live indicators, msb first as in the status register
  typedef struct packed {
    logic act;
    logic deact;
    logic sync;
    logic txc_loss;
  } lsmu_live_t;

endpackage

// ### lsmu_test.sv
// self-checking bench for the upper live line status monitor
// assumes lsmu_pkg and lsmu_top are compiled first; shortened qualification counts
`timescale 1ns/10ps

module lsmu_test;

  // ------------------------------------------------------------
  // signals and settings
  // ------------------------------------------------------------
  localparam int Q_OFF = 20;
  localparam int Q_ON  = 50;

  typedef struct packed {
    logic [7:0] ctrl;
    logic       prbs;
    logic       qrss;
    logic [7:0] live;
  } lsmu_row_t;

  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       act_ok = 1'b0;
  logic       deact_ok = 1'b0;
  logic       prbs_lock = 1'b0;
  logic       qrss_lock = 1'b0;
  logic       txc = 1'b0;
  logic       txc_run = 1'b1;
  logic       remote_loop;
  logic       irq;
  logic [7:0] got;
  int         mismatches = 0;
  int         check_count = 0;
  lsmu_row_t  rows [4];

  // 200 MHz clock
  always #2.5 clock = ~clock;

  // transmit clock toggles each cycle unless stopped
  always @(posedge clock) begin
    if (txc_run) begin
      txc <= ~txc;
    end
  end

  lsmu_top #(.QUAL_OFF(Q_OFF), .QUAL_ON(Q_ON)) u_lsmu_top (
    .CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .ACT_CODE_OK(act_ok), .DEACT_CODE_OK(deact_ok),
    .PRBS_LOCK(prbs_lock), .QRSS_LOCK(qrss_lock), .TRANSMIT_CLOCK_INPUT(txc),
    .REMOTE_LOOP(remote_loop), .IRQ(irq)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t register got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t pin got %b want %b", $time, g, e);
    end
  endtask

  // one-cycle write strobe, released at the next edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a, got);
    chk8(got, e);
  endtask

  // indicator 0 act, 1 deact, 2 sync (E1), 3 transmit clock loss
  task automatic drive_ind(input int i, input logic v);
    @(posedge clock);
    case (i)
      0: act_ok <= v;
      1: deact_ok <= v;
      2: prbs_lock <= v;
      default: txc_run <= ~v;
    endcase
  endtask

  // bounded wait for the interrupt line
  task automatic wait_irq();
    for (int k = 0; k < 150 && irq !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk1(irq, 1'b1);
    // a lost event ends the run at once
    if (irq !== 1'b1) begin
      test_done();
    end
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("CHECK FAILED %0t run did not finish", $time);
    test_done();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] bm;
    rows[0] = '{8'h02, 1'b1, 1'b0, 8'h10};
    rows[1] = '{8'h02, 1'b0, 1'b1, 8'h00};
    rows[2] = '{8'h00, 1'b0, 1'b1, 8'h10};
    rows[3] = '{8'h00, 1'b1, 1'b0, 8'h00};
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk1(irq, 1'b0);
    chk1(remote_loop, 1'b0);
    rd_chk(lsmu_pkg::IRQ_MASK_ADDR, 8'hf8);
    rd_chk(lsmu_pkg::EDGE_SELECT_ADDR, 8'h00);
    rd_chk(lsmu_pkg::LINE_CTRL_ADDR, 8'h00);
    // unmapped place reads zero and ignores writes
    wr_reg(8'h55, 8'hff);
    rd_chk(8'h55, 8'h00);
    rd_chk(lsmu_pkg::IRQ_MASK_ADDR, 8'hf8);

    // sync source per mode, repeated reads agree, masked events stay out
    foreach (rows[r]) begin
      wr_reg(lsmu_pkg::LINE_CTRL_ADDR, rows[r].ctrl);
      @(posedge clock);
      prbs_lock <= rows[r].prbs;
      qrss_lock <= rows[r].qrss;
      repeat (3) @(posedge clock);
      rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, rows[r].live);
      rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, rows[r].live);
    end
    @(posedge clock);
    prbs_lock <= 1'b0;
    qrss_lock <= 1'b0;
    rd_chk(lsmu_pkg::IRQ_STATUS_ADDR, 8'h00);
    chk1(irq, 1'b0);

    // short qualification, no loopback switching when disabled
    wr_reg(lsmu_pkg::LINE_CTRL_ADDR, 8'h00);
    drive_ind(0, 1'b1);
    repeat (Q_OFF - 6) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h00);
    repeat (10) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h40);
    chk1(remote_loop, 1'b0);
    drive_ind(0, 1'b0);
    repeat (3) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h00);

    // long qualification with switching, enter and leave remote loopback
    wr_reg(lsmu_pkg::LINE_CTRL_ADDR, 8'h01);
    drive_ind(0, 1'b1);
    repeat (Q_OFF + 6) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h00);
    repeat (Q_ON - Q_OFF) @(posedge clock);
    #1;
    chk1(remote_loop, 1'b1);
    rd_chk(lsmu_pkg::REMOTE_LOOP_STAT_ADDR, 8'h20);
    drive_ind(0, 1'b0);
    drive_ind(1, 1'b1);
    repeat (Q_ON + 8) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h20);
    chk1(remote_loop, 1'b0);
    drive_ind(1, 1'b0);
    repeat (3) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h00);

    // transmit clock loss around the 70 cycle limit
    drive_ind(3, 1'b1);
    repeat (60) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h00);
    repeat (15) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h08);
    drive_ind(3, 1'b0);
    repeat (4) @(posedge clock);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h00);

    // each indicator, each edge select: event latch, read clear, fall event
    wr_reg(lsmu_pkg::LINE_CTRL_ADDR, 8'h02);
    for (int i = 0; i < 4; i++) begin
      for (int es = 0; es < 2; es++) begin
        bm = 8'h01 << (lsmu_pkg::FLD_HI - i);
        wr_reg(lsmu_pkg::EDGE_SELECT_ADDR, (es == 1) ? bm : 8'h00);
        wr_reg(lsmu_pkg::IRQ_MASK_ADDR, ~bm);
        rd_reg(lsmu_pkg::IRQ_STATUS_ADDR, got);
        drive_ind(i, 1'b1);
        wait_irq();
        rd_chk(lsmu_pkg::IRQ_STATUS_ADDR, bm);
        chk1(irq, 1'b0);
        rd_chk(lsmu_pkg::IRQ_STATUS_ADDR, 8'h00);
        drive_ind(i, 1'b0);
        repeat (6) @(posedge clock);
        #1;
        chk1(irq, es == 1);
        rd_chk(lsmu_pkg::IRQ_STATUS_ADDR, (es == 1) ? bm : 8'h00);
      end
    end
    // write-one clear: a foreign bit keeps the request, its own bit drops it
    wr_reg(lsmu_pkg::IRQ_MASK_ADDR, 8'hef);
    drive_ind(2, 1'b1);
    wait_irq();
    wr_reg(lsmu_pkg::IRQ_STATUS_ADDR, 8'h28);
    #1;
    chk1(irq, 1'b1);
    wr_reg(lsmu_pkg::IRQ_STATUS_ADDR, 8'h10);
    #1;
    chk1(irq, 1'b0);
    rd_chk(lsmu_pkg::IRQ_STATUS_ADDR, 8'h00);

    // reset in mid-run with lock held: registers back to reset values
    @(posedge clock);
    arst_n <= 1'b0;
    #1;
    chk1(irq, 1'b0);
    @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk1(remote_loop, 1'b0);
    rd_chk(lsmu_pkg::IRQ_MASK_ADDR, 8'hf8);
    rd_chk(lsmu_pkg::LINE_CTRL_ADDR, 8'h00);
    rd_chk(lsmu_pkg::LIVE_LINE_STATUS_0_ADDR, 8'h00);
    wr_reg(lsmu_pkg::IRQ_MASK_ADDR, 8'hff);
    test_done();
  end

endmodule

// ### lsmu_top.sv
// upper live line status monitor with interrupt events
// assumes all inputs synchronous to CLOCK; detectors are outside
`timescale 1ns/10ps

// Contract
// - activate bit set after qualified detection
// - activate bit zero without activate code
// - qualification 40 ms, or 5.1 s
// - activate rise enters remote loopback
// - deactivate bit qualified, cleared when absent
// - deactivate rise leaves remote loopback
// - activate event per mask and edge
// - deactivate event per mask and edge
// - sync bit tracks E1 or T1 lock
// - sync event per mask and edge
// - loss bit after 70 idle cycles
// - loss event per mask and edge
// - events latch, read clears status
module lsmu_top #(
  parameter int QUAL_OFF = lsmu_pkg::QUAL_OFF_CYC,
  parameter int QUAL_ON  = lsmu_pkg::QUAL_ON_CYC
) (
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // detector levels and transmit clock
  input  wire logic       ACT_CODE_OK,
  input  wire logic       DEACT_CODE_OK,
  input  wire logic       PRBS_LOCK,
  input  wire logic       QRSS_LOCK,
  input  wire logic       TRANSMIT_CLOCK_INPUT,
  // results
  output logic            REMOTE_LOOP,
  output logic            IRQ
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic edge_evt(input logic cur,
                                    input logic prev,
                                    input logic es,
                                    input logic msk);
    edge_evt = ~msk & ((cur & ~prev) | (es & ~cur & prev));
  endfunction

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] r);
    hit = (a == r);
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  lsmu_pkg::lsmu_live_t        live_ff;
  lsmu_pkg::lsmu_live_t        live_d_ff;
  lsmu_pkg::lsmu_live_t        nxt_live;
  logic [lsmu_pkg::QUAL_W-1:0] act_cnt_ff;
  logic [lsmu_pkg::QUAL_W-1:0] deact_cnt_ff;
  logic [lsmu_pkg::QUAL_W-1:0] qual_lim;
  logic [lsmu_pkg::TXC_W-1:0]  txc_cnt_ff;
  logic                        txc_q_ff;
  logic [3:0]                  mask_ff;
  logic [3:0]                  es_ff;
  logic [3:0]                  ists_ff;
  logic [3:0]                  nxt_ists;
  logic [3:0]                  evt;
  logic [3:0]                  clr;
  logic [1:0]                  ctrl_ff;
  logic                        remote_ff;
  logic [7:0]                  rdata_ff;
  logic                        irq_ff;
  logic                        act_done;
  logic                        deact_done;
  logic                        act_rise;
  logic                        deact_rise;

  assign RDATA       = rdata_ff;
  assign REMOTE_LOOP = remote_ff;
  assign IRQ         = irq_ff;

  // -------------------------------------------------------------
  // loopback code qualification
  // -------------------------------------------------------------
  // window by switch mode
  assign qual_lim = ctrl_ff[lsmu_pkg::CTRL_AUTO] ?
                    lsmu_pkg::QUAL_W'(QUAL_ON) :
                    lsmu_pkg::QUAL_W'(QUAL_OFF);

  // counters saturate one past the limit, so "more than t" holds
  assign act_done   = act_cnt_ff > qual_lim;
  assign deact_done = deact_cnt_ff > qual_lim;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      act_cnt_ff <= '0;
    end else if (!ACT_CODE_OK) begin
      act_cnt_ff <= '0;
    end else if (!act_done) begin
      act_cnt_ff <= act_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      deact_cnt_ff <= '0;
    end else if (!DEACT_CODE_OK) begin
      deact_cnt_ff <= '0;
    end else if (!deact_done) begin
      deact_cnt_ff <= deact_cnt_ff + 1'b1;
    end
  end

  // -------------------------------------------------------------
  // transmit clock watchdog
  // -------------------------------------------------------------
  // idle cycle count, saturates
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      txc_q_ff   <= 1'b0;
      txc_cnt_ff <= '0;
    end else begin
      txc_q_ff <= TRANSMIT_CLOCK_INPUT;
      if (txc_q_ff != TRANSMIT_CLOCK_INPUT) begin
        txc_cnt_ff <= '0;
      end else if (txc_cnt_ff <= lsmu_pkg::TXC_LOSS_CYC) begin
        txc_cnt_ff <= txc_cnt_ff + 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // live indicators
  // -------------------------------------------------------------
  always_comb begin
    nxt_live.act       = ACT_CODE_OK & act_done;
    nxt_live.deact     = DEACT_CODE_OK & deact_done;
    nxt_live.sync      = ctrl_ff[lsmu_pkg::CTRL_E1] ?
                         PRBS_LOCK : QRSS_LOCK;
    nxt_live.txc_loss  = txc_cnt_ff > lsmu_pkg::TXC_LOSS_CYC;
  end

  // previous copy feeds the edge detectors
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      live_ff   <= '0;
      live_d_ff <= '0;
    end else begin
      live_ff   <= nxt_live;
      live_d_ff <= live_ff;
    end
  end

  // -------------------------------------------------------------
  // remote loopback switching
  // -------------------------------------------------------------
  assign act_rise   = live_ff.act & ~live_d_ff.act;
  assign deact_rise = live_ff.deact & ~live_d_ff.deact;

  // auto switch; leaving wins a tie, the safer state
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      remote_ff <= 1'b0;
    end else if (ctrl_ff[lsmu_pkg::CTRL_AUTO]) begin
      if (deact_rise) begin
        remote_ff <= 1'b0;
      end else if (act_rise) begin
        remote_ff <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // interrupt events
  // -------------------------------------------------------------
  // one edge detector per indicator
  generate
    for (genvar i = 0; i < 4; i++) begin : g_evt
      assign evt[i] = edge_evt(live_ff[i], live_d_ff[i],
                               es_ff[i], mask_ff[i]);
    end
  endgenerate

  // read or write-one clears; a new event wins
  assign clr = (RD & hit(ADDR, lsmu_pkg::IRQ_STATUS_ADDR)) ? 4'hf :
               (WR & hit(ADDR, lsmu_pkg::IRQ_STATUS_ADDR)) ?
               WDATA[lsmu_pkg::FLD_HI:lsmu_pkg::FLD_LO] : 4'h0;
  assign nxt_ists = (ists_ff & ~clr) | evt;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ists_ff <= '0;
      irq_ff  <= 1'b0;
    end else begin
      ists_ff <= nxt_ists;
      irq_ff  <= |(nxt_ists & ~mask_ff);
    end
  end

  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask_ff <= lsmu_pkg::MASK_RST;
      es_ff   <= lsmu_pkg::ES_RST;
      ctrl_ff <= lsmu_pkg::CTRL_RST;
    end else if (WR) begin
      if (hit(ADDR, lsmu_pkg::IRQ_MASK_ADDR)) begin
        mask_ff <= WDATA[lsmu_pkg::FLD_HI:lsmu_pkg::FLD_LO];
      end
      if (hit(ADDR, lsmu_pkg::EDGE_SELECT_ADDR)) begin
        es_ff <= WDATA[lsmu_pkg::FLD_HI:lsmu_pkg::FLD_LO];
      end
      if (hit(ADDR, lsmu_pkg::LINE_CTRL_ADDR)) begin
        ctrl_ff <= WDATA[lsmu_pkg::CTRL_E1:lsmu_pkg::CTRL_AUTO];
      end
    end
  end

  // -------------------------------------------------------------
  // register reads
  // -------------------------------------------------------------
  // live read only samples; reserved bits read zero, except bit 7 of the mask register, which reads one
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= '0;
      if (RD) begin
        unique case (ADDR)
          lsmu_pkg::LIVE_LINE_STATUS_0_ADDR: begin
            rdata_ff <= {1'b0, live_ff, 3'h0};
          end
          lsmu_pkg::REMOTE_LOOP_STAT_ADDR: begin
            rdata_ff[lsmu_pkg::REMOTE_BIT] <= remote_ff;
          end
          lsmu_pkg::IRQ_STATUS_ADDR: begin
            rdata_ff <= {1'b0, ists_ff, 3'h0};
          end
          lsmu_pkg::IRQ_MASK_ADDR: begin
            rdata_ff <= {1'b1, mask_ff, 3'h0};
          end
          lsmu_pkg::EDGE_SELECT_ADDR: begin
            rdata_ff <= {1'b0, es_ff, 3'h0};
          end
          lsmu_pkg::LINE_CTRL_ADDR: begin
            rdata_ff <= {6'h00, ctrl_ff};
          end
          default: begin
            rdata_ff <= '0;
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  act_qual_a: assert property (
    $rose(live_ff.act) |-> $past(act_cnt_ff) > $past(qual_lim))
    else $error("activate bit set before qualification");

  act_zero_a: assert property (
    !ACT_CODE_OK |=> !live_ff.act)
    else $error("activate bit set without code");

  qual_sel_a: assert property (
    ctrl_ff[lsmu_pkg::CTRL_AUTO] |->
      qual_lim == lsmu_pkg::QUAL_W'(QUAL_ON))
    else $error("wrong qualification window");

  loop_enter_a: assert property (
    ctrl_ff[lsmu_pkg::CTRL_AUTO] && act_rise && !deact_rise
      |=> remote_ff)
    else $error("remote loop not entered");

  deact_clr_a: assert property (
    !DEACT_CODE_OK |=> !live_ff.deact)
    else $error("deactivate bit held without code");

  loop_leave_a: assert property (
    ctrl_ff[lsmu_pkg::CTRL_AUTO] && deact_rise |=> !remote_ff)
    else $error("remote loop not left");

  act_event_a: assert property (
    !mask_ff[3] && $rose(live_ff.act) |=> ists_ff[3])
    else $error("activate event lost");

  deact_fall_a: assert property (
    !mask_ff[2] && es_ff[2] && $fell(live_ff.deact)
      |=> ists_ff[2])
    else $error("deactivate fall event lost");

  sync_track_a: assert property (
    ctrl_ff[lsmu_pkg::CTRL_E1] && $stable(ctrl_ff)
      |=> live_ff.sync == $past(PRBS_LOCK))
    else $error("sync bit not tracking lock");

  sync_edge_a: assert property (
    es_ff[1] == 1'b0 && $fell(live_ff.sync) && !ists_ff[1]
      |=> !ists_ff[1])
    else $error("falling sync raised event");

  txc_loss_a: assert property (
    $rose(live_ff.txc_loss) |-> $past(txc_q_ff, 2) ==
      $past(txc_q_ff, 72))
    else $error("loss flagged too early");

  txc_mask_a: assert property (
    mask_ff[0] && !ists_ff[0] |=> !ists_ff[0] || !$past(mask_ff[0]))
    else $error("masked loss raised event");

  live_read_a: assert property (
    RD && hit(ADDR, lsmu_pkg::LIVE_LINE_STATUS_0_ADDR)
      |=> rdata_ff[7] == 1'b0 && ists_ff == $past(nxt_ists))
    else $error("live read disturbed state");

  read_clear_a: assert property (
    RD && hit(ADDR, lsmu_pkg::IRQ_STATUS_ADDR) && evt == 4'h0
      |=> ists_ff == 4'h0 ##1 !irq_ff || ists_ff != 4'h0)
    else $error("status read did not clear");

  loop_cycle_c: cover property (
    act_rise && ctrl_ff[lsmu_pkg::CTRL_AUTO] ##[1:200] deact_rise);
  txc_loss_c:   cover property ($rose(live_ff.txc_loss));
  irq_clear_c:  cover property ($rose(irq_ff) ##[1:20] $fell(irq_ff));

endmodule
